//--- pkg/pmsr_pkg.sv
// pmsr_pkg: constants and types for the power mode / supply monitor block
// assumes a 20 MHz aclk and an AXI4-Lite master with 32-bit data
package pmsr_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  typedef logic [ADDR_W-1:0]   pmsr_addr_t;
  typedef logic [DATA_W-1:0]   pmsr_data_t;
  typedef logic [DATA_W/8-1:0] pmsr_strb_t;
  typedef logic [1:0]          pmsr_resp_t;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_MODE_CTRL   = 12'h087;
  localparam logic [ADDR_W-1:0] IDX_MON_CTRL    = 12'h0FF;
  localparam logic [ADDR_W-1:0] IDX_RST_SOURCE  = 12'h0EF;
  localparam logic [ADDR_W-1:0] IDX_BLOCK_STAT  = 12'h0F0;
  localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL  = 12'h21C;
  localparam logic [ADDR_W-1:0] ADDR_MON_CTRL   = 12'h3FC;
  localparam logic [ADDR_W-1:0] ADDR_RST_SOURCE = 12'h3BC;
  localparam logic [ADDR_W-1:0] ADDR_BLOCK_STAT = 12'h3C0;

  // power_mode_control fields
  localparam int FLAGS_LSB = 2;
  localparam int FLAGS_W   = 6;
  localparam int STOP_BIT  = 1;
  localparam int IDLE_BIT  = 0;
  localparam logic [FLAGS_W-1:0] FLAGS_RESET = 6'h00;

  // supply_monitor_control fields
  localparam int MON_EN_BIT   = 7;
  localparam int SUPPLY_BIT   = 6;
  // reset_source_register field
  localparam int POR_FLAG_BIT = 1;
  // block status fields
  localparam int ST_CPU_CLK_BIT = 0;
  localparam int ST_OSC_BIT     = 1;
  localparam int ST_CPU_RST_BIT = 2;
  localparam int ST_STABLE_BIT  = 3;

  // monitor turn-on time
  localparam int MON_TURN_ON_NS = 100000;
  localparam int CLK_PERIOD_NS  = 50;
  localparam int MON_TURN_ON_CYC =
    (MON_TURN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_W = 12;

  localparam pmsr_resp_t RESP_OKAY   = 2'h0;
  localparam pmsr_resp_t RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_STOP
  } pmsr_mode_t;

endpackage : pmsr_pkg

//--- rtl/pmsr_sync3.sv
// pmsr_sync3: three-stage synchroniser for a pin level
// assumes the input is asynchronous to aclk
`timescale 1ns/1ns
module pmsr_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change accepted once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule : pmsr_sync3

//--- rtl/pmsr_top.sv
// pmsr_top: power mode control and supply monitor reset, AXI4-Lite slave
// assumes aclk keeps running in stop mode; irq_pending from aclk logic;
// supply_above and power_on_n come from analog pins
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module pmsr_top
  import pmsr_pkg::*;
#(
  parameter int TURN_ON_CYC = pmsr_pkg::MON_TURN_ON_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire pmsr_pkg::pmsr_addr_t s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire pmsr_pkg::pmsr_data_t s_axi_wdata,
  input  wire pmsr_pkg::pmsr_strb_t s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output pmsr_pkg::pmsr_resp_t      s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire pmsr_pkg::pmsr_addr_t s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output pmsr_pkg::pmsr_data_t      s_axi_rdata,
  output pmsr_pkg::pmsr_resp_t      s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 supply_above,
  input  wire logic                 power_on_n,
  input  wire logic                 irq_pending,
  output logic                      cpu_clk_en,
  output logic                      osc_run,
  output logic                      cpu_reset_n,
  output logic                      rst_pin_out,
  output logic                      rst_pin_oe
);
  import pmsr_pkg::*;

  logic                 supply_s;
  logic                 power_on_n_s;
  logic                 por_active;
  logic                 aw_hold_q;
  logic                 w_hold_q;
  pmsr_addr_t           aw_addr_q;
  pmsr_data_t           w_data_q;
  pmsr_strb_t           w_strb_q;
  logic                 wr_go;
  logic                 wr_lane0;
  logic                 wr_hit;
  logic                 rd_hit;
  pmsr_data_t           rd_data;
  logic [FLAGS_W-1:0]   flags_q;
  logic                 mon_en_q;
  logic                 src_sel_q;
  logic                 por_flag_q;
  logic [STAB_W-1:0]    stab_cnt_q;
  logic                 stable_q;
  logic                 trip;
  pmsr_mode_t           mode_q;
  logic                 mode_wr;

  pmsr_sync3 #(
    .RESET_VAL (1'b0)
  ) u_sync_supply (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (supply_above),
    .level_q (supply_s)
  );

  pmsr_sync3 #(
    .RESET_VAL (1'b1)
  ) u_sync_por (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (power_on_n),
    .level_q (power_on_n_s)
  );

  assign por_active = !power_on_n_s;

  // ---- write channel: address and data taken in either order
  assign wr_go    = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_lane0 = wr_go && w_strb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_hold_q     <= 1'b0;
      aw_addr_q     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_q     <= 1'b0;
    end else if (!aw_hold_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_hold_q     <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold_q     <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_q     <= 1'b0;
    end else if (!w_hold_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    case (aw_addr_q)
      ADDR_MODE_CTRL,
      ADDR_MON_CTRL,
      ADDR_RST_SOURCE,
      ADDR_BLOCK_STAT: wr_hit = 1'b1;
      default:         wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---- read channel
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      ADDR_MODE_CTRL:  rd_data[FLAGS_LSB +: FLAGS_W] = flags_q;
      ADDR_MON_CTRL: begin
        rd_data[MON_EN_BIT] = mon_en_q;
        rd_data[SUPPLY_BIT] = supply_s;
      end
      ADDR_RST_SOURCE: rd_data[POR_FLAG_BIT] = por_flag_q;
      ADDR_BLOCK_STAT: begin
        rd_data[ST_CPU_CLK_BIT] = cpu_clk_en;
        rd_data[ST_OSC_BIT]     = osc_run;
        rd_data[ST_CPU_RST_BIT] = !cpu_reset_n;
        rd_data[ST_STABLE_BIT]  = stable_q;
      end
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- power_mode_control storage
  // flags stored only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= FLAGS_RESET;
    end else if (wr_lane0 && aw_addr_q == ADDR_MODE_CTRL) begin
      flags_q <= w_data_q[FLAGS_LSB +: FLAGS_W];
    end
  end

  // ---- supply monitor enable, kept across system resets
  // power-on sets it, a write sets or clears it; aresetn leaves it
  always_ff @(posedge aclk) begin
    if (por_active) begin
      mon_en_q <= 1'b1;
    end else if (wr_lane0 && aw_addr_q == ADDR_MON_CTRL) begin
      mon_en_q <= w_data_q[MON_EN_BIT];
    end
  end

  // turn-on time after enable
  always_ff @(posedge aclk) begin
    if (!aresetn || !mon_en_q) begin
      stab_cnt_q <= '0;
      stable_q   <= 1'b0;
    end else if (stab_cnt_q == STAB_W'(TURN_ON_CYC - 1)) begin
      stable_q   <= 1'b1;
    end else begin
      stab_cnt_q <= stab_cnt_q + STAB_W'(1);
    end
  end

  // monitor chosen as reset source; software orders this
  always_ff @(posedge aclk) begin
    if (!aresetn || por_active) begin
      src_sel_q <= 1'b0;
    end else if (wr_lane0 && aw_addr_q == ADDR_RST_SOURCE) begin
      src_sel_q <= w_data_q[POR_FLAG_BIT];
    end
  end

  // only when selected; unstable monitor trips
  assign trip = src_sel_q && (!mon_en_q || !stable_q || !supply_s);

  always_ff @(posedge aclk) begin
    if (por_active || trip) begin
      por_flag_q <= 1'b1;
    end else if (wr_lane0 && aw_addr_q == ADDR_RST_SOURCE &&
                 !w_data_q[POR_FLAG_BIT]) begin
      por_flag_q <= 1'b0;
    end
  end

  // ---- reset drive
  // follow trip one aclk cycle later (registered)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_reset_n <= 1'b0;
      rst_pin_oe  <= 1'b0;
    end else begin
      cpu_reset_n <= !(trip || por_active);
      rst_pin_oe  <= trip;
    end
  end

  // open-drain pin only ever pulls low
  always_ff @(posedge aclk) begin
    rst_pin_out <= 1'b0;
  end

  // ---- idle and stop modes
  assign mode_wr = wr_lane0 && aw_addr_q == ADDR_MODE_CTRL;

  always_ff @(posedge aclk) begin
    if (!aresetn || por_active || trip) begin
      mode_q <= MODE_RUN;
    end else begin
      case (mode_q)
        MODE_RUN: begin
          if (mode_wr && w_data_q[STOP_BIT]) begin
            mode_q <= MODE_STOP;
          end else if (mode_wr && w_data_q[IDLE_BIT]) begin
            mode_q <= MODE_IDLE;
          end
        end
        MODE_IDLE: begin
          if (irq_pending) begin
            mode_q <= MODE_RUN;
          end
        end
        MODE_STOP: mode_q <= MODE_STOP;
        default:   mode_q <= MODE_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en <= 1'b1;
      osc_run    <= 1'b1;
    end else begin
      cpu_clk_en <= (mode_q == MODE_RUN);
      osc_run    <= (mode_q != MODE_STOP);
    end
  end

endmodule : pmsr_top

//--- tb/pmsr_chk.sv
// pmsr_chk: port assertions for pmsr_top
// assumes one aclk domain, synchronous active-low aresetn
`timescale 1ns/1ns
module pmsr_chk (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire pmsr_pkg::pmsr_data_t s_axi_rdata,
  input wire logic                 irq_pending,
  input wire logic                 cpu_clk_en,
  input wire logic                 osc_run,
  input wire logic                 cpu_reset_n,
  input wire logic                 rst_pin_out,
  input wire logic                 rst_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (w_take |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data not one cycle after handshake");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_pin_value: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("reset pin driven high");
  a_pin_holds_cpu: assert property (rst_pin_oe |-> !cpu_reset_n)
    else $error("reset pin low but cpu running");
  a_stop_gates: assert property (!osc_run |-> !cpu_clk_en)
    else $error("cpu clock with oscillator halted");
  a_idle_wake: assert property (
    irq_pending && !cpu_clk_en && osc_run |-> ##[1:3] cpu_clk_en)
    else $error("idle not left on interrupt");
  a_stop_exit: assert property ($rose(osc_run) |-> ##[0:1] !cpu_reset_n)
    else $error("stop left without reset");
endmodule : pmsr_chk

bind pmsr_top pmsr_chk u_pmsr_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
  .irq_pending, .cpu_clk_en, .osc_run, .cpu_reset_n, .rst_pin_out,
  .rst_pin_oe);

//--- tb/pmsr_top_test.sv
// pmsr_top_test: self-checking bench for pmsr_top
// assumes pmsr_chk is bound; bench acts as the AXI4-Lite master
`timescale 1ns/1ns
module pmsr_top_test;
  import pmsr_pkg::*;
  localparam int T_ON = 8;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid,
    s_axi_arready, s_axi_rvalid, s_axi_rready, supply_above,
    power_on_n, irq_pending, cpu_clk_en, osc_run, cpu_reset_n,
    rst_pin_out, rst_pin_oe;
  pmsr_addr_t s_axi_awaddr, s_axi_araddr;
  pmsr_data_t s_axi_wdata, s_axi_rdata;
  pmsr_strb_t s_axi_wstrb;
  pmsr_resp_t s_axi_bresp, s_axi_rresp;

  pmsr_top #(.TURN_ON_CYC(T_ON)) u_pmsr_top (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .supply_above, .power_on_n, .irq_pending,
    .cpu_clk_en, .osc_run, .cpu_reset_n, .rst_pin_out, .rst_pin_oe);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic conclude;
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      err_count = err_count + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask : step

  task automatic wr(input pmsr_addr_t a, input pmsr_data_t d,
                    input pmsr_resp_t er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input pmsr_addr_t a, input pmsr_data_t ed);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(RESP_OKAY));
  endtask : rd

  task automatic t_regs;
    rd(ADDR_MODE_CTRL, 32'h00);
    wr(ADDR_MODE_CTRL, 32'hFC, RESP_OKAY);
    rd(ADDR_MODE_CTRL, 32'hFC);
    chk(cpu_clk_en, 1'b1);
    chk(osc_run, 1'b1);
    s_axi_wstrb <= 4'hE;
    wr(ADDR_MODE_CTRL, 32'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(ADDR_MODE_CTRL, 32'hFC);
    rd(ADDR_MON_CTRL, 32'hC0);
    rd(ADDR_BLOCK_STAT, 32'h0B);
    rd(ADDR_RST_SOURCE, 32'h02);
    wr(12'h010, 32'hFF, RESP_SLVERR);
  endtask : t_regs

  task automatic t_idle;
    wr(ADDR_MODE_CTRL, 32'h05, RESP_OKAY);
    step(3);
    chk(cpu_clk_en, 1'b0);
    chk(osc_run, 1'b1);
    rd(ADDR_MODE_CTRL, 32'h04);
    irq_pending <= 1'b1;
    step(4);
    irq_pending <= 1'b0;
    chk(cpu_clk_en, 1'b1);
  endtask : t_idle

  task automatic t_stop;
    wr(ADDR_MON_CTRL, 32'h00, RESP_OKAY);
    wr(ADDR_MODE_CTRL, 32'h07, RESP_OKAY);
    step(3);
    chk(osc_run, 1'b0);
    chk(cpu_clk_en, 1'b0);
    rd(ADDR_MODE_CTRL, 32'h04);
    irq_pending <= 1'b1;
    step(4);
    irq_pending <= 1'b0;
    chk(osc_run, 1'b0);
    aresetn <= 1'b0;
    step(12);
    aresetn <= 1'b1;
    step(3);
    chk(osc_run, 1'b1);
    chk(cpu_clk_en, 1'b1);
    rd(ADDR_MON_CTRL, 32'h40);
    rd(ADDR_MODE_CTRL, 32'h00);
  endtask : t_stop

  task automatic t_trip;
    wr(ADDR_RST_SOURCE, 32'h02, RESP_OKAY);
    step(3);
    chk(cpu_reset_n, 1'b0);
    wr(ADDR_RST_SOURCE, 32'h00, RESP_OKAY);
    step(3);
    chk(cpu_reset_n, 1'b1);
    wr(ADDR_RST_SOURCE, 32'h00, RESP_OKAY);
    rd(ADDR_RST_SOURCE, 32'h00);
    wr(ADDR_MON_CTRL, 32'h80, RESP_OKAY);
    supply_above <= 1'b0;
    step(T_ON + 4);
    chk(cpu_reset_n, 1'b1);
    rd(ADDR_MON_CTRL, 32'h80);
    supply_above <= 1'b1;
    step(6);
    wr(ADDR_RST_SOURCE, 32'h02, RESP_OKAY);
    step(4);
    chk(cpu_reset_n, 1'b1);
    rd(ADDR_RST_SOURCE, 32'h00);
    supply_above <= 1'b0;
    step(6);
    chk(rst_pin_oe, 1'b1);
    chk(cpu_reset_n, 1'b0);
    chk(rst_pin_out, 1'b0);
    rd(ADDR_RST_SOURCE, 32'h02);
    supply_above <= 1'b1;
    step(6);
    chk(cpu_reset_n, 1'b1);
    chk(rst_pin_oe, 1'b0);
    wr(ADDR_MODE_CTRL, 32'h02, RESP_OKAY);
    step(3);
    chk(osc_run, 1'b0);
    supply_above <= 1'b0;
    step(7);
    chk(osc_run, 1'b1);
    chk(cpu_reset_n, 1'b0);
    supply_above <= 1'b1;
    step(6);
    chk(cpu_reset_n, 1'b1);
  endtask : t_trip

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, irq_pending} = 3'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    supply_above = 1'b1;
    power_on_n = 1'b1;
    aresetn = 1'b0;
    step(12);
    aresetn <= 1'b1;
    power_on_n <= 1'b0;
    step(8);
    power_on_n <= 1'b1;
    step(T_ON + 8);
    t_regs();
    t_idle();
    t_stop();
    t_trip();
    conclude();
  end
endmodule : pmsr_top_test
